// File: hw/sfl_defines.svh
/*
  Opcodes, bit counts, array geometry and host timing for the serial flash
  mode, hold and protection logic.
  Assumes it is included by its bare name from hw/.
*/
`ifndef SFL_DEFINES_SVH
`define SFL_DEFINES_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SFL_OP_SET_WEL  8'h06
`define SFL_OP_CLR_WEL  8'h04
`define SFL_OP_STATUS_WRITE_CMD     8'h01
`define SFL_OP_RDSR     8'h05
`define SFL_OP_PP       8'h02
`define SFL_OP_QPP      8'h32
`define SFL_OP_SE       8'h20
`define SFL_OP_BE32     8'h52
`define SFL_OP_BE64     8'hd8
`define SFL_OP_CE1      8'h60
`define SFL_OP_CE2      8'hc7
`define SFL_OP_ESR      8'h44
`define SFL_OP_PSR      8'h42
`define SFL_OP_DP       8'hb9
`define SFL_OP_RDP      8'hab
`define SFL_OP_QPI_ON   8'h38
`define SFL_OP_QPI_OFF  8'hff
`define SFL_OP_RST_EN   8'h66
`define SFL_OP_RST      8'h99
`define SFL_OP_DIOR     8'hbb
`define SFL_OP_QOR      8'h6b
`define SFL_OP_QIOR     8'heb
`define SFL_OP_QWR      8'he7

// ----------------------------------------
// Frame and array geometry, hardware lock code, host half period
// ----------------------------------------
`define SFL_OPC_BITS    6'd8
`define SFL_ADDR_BITS   6'd24
`define SFL_DATA_BITS   6'd8
`define SFL_CNT_MAX     6'h3f
`define SFL_SECTORS     11'd1024
`define SFL_BLK_SECT    11'd16
`define SFL_B32_SECT    11'd8
`define SFL_LOCK_HW     2'b01
`define SFL_HOST_HALF   3'd3

`endif

// File: hw/sfl_device.sv
/*
  Flash device end: lane handling, hold, four-lane command mode, write enable
  latch, deep power-down and block protection checks.
  Assumes the link clock comes from the host, settings arrive as quasi-static levels
  on core_clk, and rst stands for power-up.
*/
// What this block does
// (R1) Serial modes 0 and 3 only
// (R2) Capture on rising, drive on falling clock
// (R3) Dual commands use lanes 0 and 1
// (R4) Quad commands add lanes 2 and 3
// (R5) Quad commands need quad enable set
// (R6) Enter/exit opcodes switch four-lane command mode
// (R7) Power-up and reset leave four-lane mode
// (R8) Four-lane mode entry needs quad enable
// (R9) Hold pauses link, not internal operations
// (R10) Hold starts and ends with clock low
// (R11) Hold floats output, ignores input and clock
// (R12) Chip select high during hold resets interface
// (R13) Write enable latch set and clear events
// (R14) Write-protect low freezes protect and lock bits
// (R15) Deep power-down ignores all but release; link still answers status read
// (R16) Protected region readable, never programmed or erased
// (R17) Block-sized protection top or bottom
// (R18) Sector-sized protection with protect bit 4
// (R19) Complement protects the opposite range
// (R20) 1024 sectors, sixteen per block
// (R21) Writes need the write enable latch
// (R22) Hardware lock only for lock bits 0,1
// (R23) Protected program or erase is discarded
`include "sfl_defines.svh"
module sfl_device (
  // Link
  sfl_link_if.device      link,
  // Core clock and power-up reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Settings and internal state
  input  wire logic       quad_enable,
  input  wire logic       protect_complement,
  input  wire logic [4:0] protect_bits,
  input  wire logic [1:0] status_lock,
  input  wire logic       busy,
  // Mode and command results
  output logic            four_lane_command_mode_q,
  output logic            write_enable_latch_q,
  output logic            deep_power_down_q,
  output logic            hold_active_q,
  output logic            op_go_q,
  output logic            op_refused_q,
  output logic [7:0]      op_code_q,
  output logic [23:0]     op_addr_q
);
  // ----------------------------------------
  // Link domain
  // ----------------------------------------
  logic                   link_rst;
  logic                   link_hold;
  logic [4:0]             ls2_q;
  logic [5:0]             bit_cnt_q;
  logic [5:0]             bit_cnt_d;
  logic [31:0]            shift_q;
  logic [31:0]            shift_d;
  sfl_pkg::sfl_opcode_type op_q;
  logic [2:0]             lane_w;
  logic                   fire;
  logic                   evt_tgl_q;
  sfl_pkg::sfl_opcode_type evt_op_q;
  logic [23:0]            evt_pl_q;
  logic [7:0]             out_sh_q;
  logic                   out_oe_q;

  function automatic logic [5:0] payload_len(input logic [7:0] op);
    unique case (op)
      `SFL_OP_STATUS_WRITE_CMD: payload_len = `SFL_DATA_BITS;
      `SFL_OP_PP, `SFL_OP_QPP, `SFL_OP_SE, `SFL_OP_BE32, `SFL_OP_BE64: payload_len = `SFL_ADDR_BITS;
      default: payload_len = 6'h00;
    endcase
  endfunction

  assign link_rst  = rst | link.cs_n; // R12
  assign link_hold = ~ls2_q[2] & ~link.lane[3]; // R10 R11

  // Settings held for the whole frame
  always_ff @(negedge link.cs_n or posedge rst) begin
    if (rst) begin
      ls2_q <= 5'h00;
    end else begin
      ls2_q <= {hold_active_q, busy, quad_enable, four_lane_command_mode_q, write_enable_latch_q};
    end
  end

  always_comb begin
    if (ls2_q[1]) begin
      lane_w = 3'd4; // R6
    end else if (bit_cnt_q < `SFL_OPC_BITS) begin
      lane_w = 3'd1; // R1
    end else if ((op_q == `SFL_OP_QIOR || op_q == `SFL_OP_QWR) && ls2_q[2]) begin
      lane_w = 3'd4; // R4
    end else if (op_q == `SFL_OP_DIOR) begin
      lane_w = 3'd2; // R3
    end else begin
      lane_w = 3'd1;
    end
    unique case (lane_w)
      3'd4:    shift_d = {shift_q[27:0], link.lane[3:0]};
      3'd2:    shift_d = {shift_q[29:0], link.lane[1:0]};
      default: shift_d = {shift_q[30:0], link.lane[0]};
    endcase
    bit_cnt_d = (bit_cnt_q > `SFL_CNT_MAX - 6'd4) ? `SFL_CNT_MAX : bit_cnt_q + 6'(lane_w);
    if (bit_cnt_d == `SFL_OPC_BITS) begin
      fire = ~link_hold && (payload_len(shift_d[7:0]) == 6'h00);
    end else begin
      fire = ~link_hold && (bit_cnt_q >= `SFL_OPC_BITS) && (bit_cnt_q < `SFL_OPC_BITS + payload_len(op_q))
             && (bit_cnt_d == `SFL_OPC_BITS + payload_len(op_q));
    end
  end

  // Bit capture on the rising edge
  always_ff @(posedge link.sclk or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_q <= 6'h00;
      shift_q   <= 32'h0000_0000;
      op_q      <= 8'h00;
    end else if (!link_hold) begin // R11
      bit_cnt_q <= bit_cnt_d; // R2
      shift_q   <= shift_d;
      if (bit_cnt_d == `SFL_OPC_BITS) begin
        op_q <= shift_d[7:0];
      end
    end
  end

  // Command event towards the core clock
  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      evt_tgl_q <= 1'b0;
      evt_op_q  <= 8'h00;
      evt_pl_q  <= 24'h00_0000;
    end else if (fire) begin
      evt_tgl_q <= ~evt_tgl_q;
      evt_op_q  <= (bit_cnt_d == `SFL_OPC_BITS) ? shift_d[7:0] : op_q;
      evt_pl_q  <= shift_d[23:0];
    end
  end

  // Status byte out on the falling edge
  always_ff @(negedge link.sclk or posedge link_rst) begin
    if (link_rst) begin
      out_sh_q <= 8'h00;
      out_oe_q <= 1'b0;
    end else if (link_hold) begin
      out_sh_q <= out_sh_q; // R11
    end else if (bit_cnt_q == `SFL_OPC_BITS && op_q == `SFL_OP_RDSR && !ls2_q[1]) begin
      out_sh_q <= {6'h00, ls2_q[0], ls2_q[3]}; // R2
      out_oe_q <= 1'b1;
    end else begin
      out_sh_q <= {out_sh_q[6:0], 1'b0};
    end
  end

  assign link.dev_do = {2'b00, out_sh_q[7], 1'b0};
  assign link.dev_oe = {2'b00, out_oe_q & ~link_hold, 1'b0}; // R11

  // ----------------------------------------
  // Core domain
  // ----------------------------------------
  logic [3:0]             p1_q;
  logic [3:0]             p2_q;
  logic [3:0]             p3_q;
  logic [3:0]             pf_q;
  logic [2:0]             ev_q;
  logic                   ev_fire;
  logic                   wp_low;
  logic                   lock;
  logic                   hit;
  logic                   armed_q;
  logic [10:0]            tgt_s0;
  logic [10:0]            tgt_n;

  function automatic logic prot_hit(input logic [4:0] bp, input logic cmp,
                                    input logic [10:0] s0, input logic [10:0] n);
    logic [10:0] size;
    logic [10:0] lo;
    logic [10:0] hi;
    logic [10:0] s_end;
    if (bp[2:0] == 3'd0) begin
      size = 11'd0;
    end else if (bp[2:0] == 3'd7) begin
      size = `SFL_SECTORS; // R17
    end else if (!bp[4]) begin
      size = 11'(`SFL_BLK_SECT << (bp[2:0] - 3'd1)); // R17
    end else begin
      unique case (bp[2:0])
        3'd1:    size = 11'd1; // R18
        3'd2:    size = 11'd2;
        3'd3:    size = 11'd4;
        default: size = `SFL_B32_SECT;
      endcase
    end
    lo    = bp[3] ? 11'd0 : `SFL_SECTORS - size;
    hi    = bp[3] ? size : `SFL_SECTORS;
    s_end = s0 + n;
    if (cmp) begin
      prot_hit = !(s0 >= lo && s_end <= hi); // R19
    end else begin
      prot_hit = (s0 < hi) && (s_end > lo); // R16
    end
  endfunction

  // Pin inputs: sclk, cs_n, write-protect, hold
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      p1_q <= 4'hf;
      p2_q <= 4'hf;
      p3_q <= 4'hf;
      pf_q <= 4'hf;
    end else begin
      p1_q <= {link.lane[3], link.lane[2], link.cs_n, link.sclk};
      p2_q <= p1_q;
      p3_q <= p2_q;
      pf_q <= (p2_q & ~(p2_q ^ p3_q)) | (pf_q & (p2_q ^ p3_q));
    end
  end

  // Hold state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hold_active_q <= 1'b0;
    end else if (pf_q[1] || quad_enable) begin
      hold_active_q <= 1'b0; // R12
    end else if (!pf_q[0]) begin
      hold_active_q <= ~pf_q[3]; // R10 R9
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ev_q <= 3'b000;
    end else begin
      ev_q <= {ev_q[1:0], evt_tgl_q};
    end
  end

  assign ev_fire = ev_q[2] ^ ev_q[1];
  assign wp_low  = ~quad_enable & ~pf_q[2];
  assign lock    = ((status_lock == `SFL_LOCK_HW) && wp_low) || status_lock[1]; // R14 R22

  always_comb begin
    unique case (evt_op_q)
      `SFL_OP_SE, `SFL_OP_PP, `SFL_OP_QPP: begin
        tgt_s0 = {1'b0, evt_pl_q[21:12]};
        tgt_n  = 11'd1;
      end
      `SFL_OP_BE32: begin
        tgt_s0 = {1'b0, evt_pl_q[21:15], 3'b000};
        tgt_n  = `SFL_B32_SECT;
      end
      `SFL_OP_BE64: begin
        tgt_s0 = {1'b0, evt_pl_q[21:16], 4'h0}; // R20
        tgt_n  = `SFL_BLK_SECT;
      end
      default: begin
        tgt_s0 = 11'd0;
        tgt_n  = `SFL_SECTORS;
      end
    endcase
    hit = prot_hit(protect_bits, protect_complement, tgt_s0, tgt_n);
  end

  // Command execution
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      four_lane_command_mode_q <= 1'b0; // R7
      write_enable_latch_q     <= 1'b0; // R13
      deep_power_down_q        <= 1'b0;
      armed_q                  <= 1'b0;
      op_go_q                  <= 1'b0;
      op_refused_q             <= 1'b0;
      op_code_q                <= 8'h00;
      op_addr_q                <= 24'h00_0000;
    end else begin
      op_go_q      <= 1'b0;
      op_refused_q <= 1'b0;
      if (ev_fire) begin
        op_code_q <= evt_op_q;
        op_addr_q <= evt_pl_q;
        armed_q   <= (evt_op_q == `SFL_OP_RST_EN) && !deep_power_down_q;
        if (deep_power_down_q) begin
          deep_power_down_q <= (evt_op_q != `SFL_OP_RDP); // R15
        end else begin
          unique case (evt_op_q)
            `SFL_OP_SET_WEL: write_enable_latch_q <= 1'b1; // R13
            `SFL_OP_CLR_WEL: write_enable_latch_q <= 1'b0; // R13
            `SFL_OP_DP:      deep_power_down_q <= 1'b1;
            `SFL_OP_QPI_ON: begin
              four_lane_command_mode_q <= quad_enable; // R8 R6
              op_refused_q             <= ~quad_enable;
            end
            `SFL_OP_QPI_OFF: four_lane_command_mode_q <= 1'b0; // R6
            `SFL_OP_RST: begin
              if (armed_q) begin
                four_lane_command_mode_q <= 1'b0; // R7
                write_enable_latch_q     <= 1'b0;
              end
            end
            `SFL_OP_STATUS_WRITE_CMD, `SFL_OP_ESR, `SFL_OP_PSR: begin
              if (write_enable_latch_q && !busy && !(lock && evt_op_q == `SFL_OP_STATUS_WRITE_CMD)) begin // R21 R14
                op_go_q              <= 1'b1;
                write_enable_latch_q <= 1'b0; // R13
              end else begin
                op_refused_q <= 1'b1;
              end
            end
            `SFL_OP_PP, `SFL_OP_QPP, `SFL_OP_SE, `SFL_OP_BE32, `SFL_OP_BE64, `SFL_OP_CE1, `SFL_OP_CE2: begin
              if (write_enable_latch_q && !busy && !hit && (evt_op_q != `SFL_OP_QPP || quad_enable)) begin // R21 R5
                op_go_q              <= 1'b1;
                write_enable_latch_q <= 1'b0; // R13
              end else begin
                op_refused_q <= 1'b1; // R23 R16
              end
            end
            `SFL_OP_QOR, `SFL_OP_QIOR, `SFL_OP_QWR: op_refused_q <= ~quad_enable; // R5
            default: op_refused_q <= 1'b0;
          endcase
        end
      end
    end
  end
endmodule

// File: hw/sfl_host.sv
/*
  Flash host end: divides core_clk into the link clock (mode 0), frames one
  command with optional payload and optional one-byte read, and drives hold and
  write-protect levels.
  Assumes the device answers reads on lane 1 after the command and payload, before chip select rises.
*/
`include "sfl_defines.svh"
module sfl_host (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Request
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_opcode,
  input  wire logic [23:0] req_payload,
  input  wire logic [5:0]  req_payload_bits,
  input  wire logic        req_four_lane,
  input  wire logic        req_read,
  output logic             req_ready_q,
  // Answer
  output logic             rd_valid_q,
  output logic [7:0]       rd_data_q,
  // Pin levels
  input  wire logic        hold_req,
  input  wire logic        wp_level,
  // Link
  sfl_link_if.host         link
);
  sfl_pkg::sfl_host_state_type state_q;
  logic [2:0]              div_q;
  logic                    tick;
  logic                    sclk_q;
  logic                    cs_n_q;
  logic                    hold_q;
  logic [31:0]             sh_q;
  logic [5:0]              left_q;
  logic                    four_q;
  logic                    read_q;
  logic [3:0]              do_q;
  logic [3:0]              oe_q;

  assign tick         = (div_q == `SFL_HOST_HALF - 3'd1) && !hold_q && (four_q || do_q[3]);
  assign link.sclk    = sclk_q;
  assign link.cs_n    = cs_n_q;
  assign link.host_do = do_q;
  assign link.host_oe = oe_q;

  // ----------------------------------------
  // Clock divider and hold
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_q  <= 3'd0;
      hold_q <= 1'b0;
    end else begin
      div_q <= (tick || state_q == sfl_pkg::SFL_IDLE) ? 3'd0 : div_q + 3'd1;
      if (!sclk_q && !tick) begin
        hold_q <= hold_req; // R10
      end
    end
  end

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q     <= sfl_pkg::SFL_IDLE;
      sclk_q      <= 1'b0;
      cs_n_q      <= 1'b1;
      sh_q        <= 32'h0000_0000;
      left_q      <= 6'd0;
      four_q      <= 1'b0;
      read_q      <= 1'b0;
      do_q        <= 4'hc;
      oe_q        <= 4'hc;
      req_ready_q <= 1'b1;
      rd_valid_q  <= 1'b0;
      rd_data_q   <= 8'h00;
    end else begin
      rd_valid_q <= 1'b0;
      if (!four_q || state_q == sfl_pkg::SFL_IDLE) begin
        do_q[3:2] <= {~hold_q, wp_level};
      end
      unique case (state_q)
        sfl_pkg::SFL_IDLE: begin
          if (req_valid && !hold_q && !hold_req) begin // R12
            state_q     <= sfl_pkg::SFL_SEND;
            cs_n_q      <= 1'b0;
            req_ready_q <= 1'b0;
            sh_q        <= {req_opcode, req_payload};
            left_q      <= `SFL_OPC_BITS + req_payload_bits;
            four_q      <= req_four_lane;
            read_q      <= req_read;
            do_q        <= req_four_lane ? req_opcode[7:4] : {~hold_q, wp_level, 1'b0, req_opcode[7]};
            oe_q        <= req_four_lane ? 4'hf : 4'hd; // R4 R1
          end
        end
        sfl_pkg::SFL_SEND: begin
          if (tick) begin
            sclk_q <= ~sclk_q;
            if (!sclk_q) begin
              left_q <= left_q - (four_q ? 6'd4 : 6'd1);
            end else if (left_q == 6'd0) begin
              state_q <= read_q ? sfl_pkg::SFL_READ : sfl_pkg::SFL_FINISH;
              left_q  <= `SFL_DATA_BITS;
              oe_q    <= four_q ? 4'h0 : 4'hc;
            end else if (four_q) begin
              sh_q      <= {sh_q[27:0], 4'h0};
              do_q      <= sh_q[27:24];
            end else begin
              sh_q      <= {sh_q[30:0], 1'b0};
              do_q[0]   <= sh_q[30];
            end
          end
        end
        sfl_pkg::SFL_READ: begin
          if (tick) begin
            sclk_q <= ~sclk_q;
            if (!sclk_q) begin
              rd_data_q <= {rd_data_q[6:0], link.lane[1]};
              left_q    <= left_q - 6'd1;
            end else if (left_q == 6'd0) begin
              state_q <= sfl_pkg::SFL_FINISH;
            end
          end
        end
        sfl_pkg::SFL_FINISH: begin
          if (tick) begin
            state_q     <= sfl_pkg::SFL_IDLE;
            cs_n_q      <= 1'b1;
            oe_q        <= 4'hc;
            four_q      <= 1'b0;
            req_ready_q <= 1'b1;
            rd_valid_q  <= read_q;
          end
        end
      endcase
    end
  end
endmodule

// File: hw/sfl_link_if.sv
/*
  Pin bundle between the flash host and the flash device.
  Assumes four data lanes with a weak pull-up; each side drives with its own enable.
*/
interface sfl_link_if;
  logic       sclk;
  logic       cs_n;
  logic [3:0] host_do;
  logic [3:0] host_oe;
  logic [3:0] dev_do;
  logic [3:0] dev_oe;
  logic [3:0] lane;

  // ----------------------------------------
  // Wire level from the enables
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane[i] = host_oe[i] ? host_do[i] : (dev_oe[i] ? dev_do[i] : 1'b1);
    end
  end

  modport host   (output sclk, output cs_n, output host_do, output host_oe, input lane);
  modport device (input sclk, input cs_n, output dev_do, output dev_oe, input lane);
endinterface

// File: hw/sfl_pkg.sv
/*
  Shared types for both ends of the serial flash link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sfl_pkg;
  typedef logic [7:0] sfl_opcode_type;
  typedef enum logic [1:0] {SFL_IDLE, SFL_SEND, SFL_READ, SFL_FINISH} sfl_host_state_type;
endpackage

// File: testbench/serial_flash_mode_hold_protect_test.sv
/*
  Self-checking bench: host and device ends joined by the link interface.
  Assumes the files under hw/ are compiled first.
*/
`include "sfl_defines.svh"
module serial_flash_mode_hold_protect_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid = 1'b0;
  logic [7:0]  req_opcode = 8'h00;
  logic [23:0] req_payload = 24'h000000;
  logic [5:0]  req_payload_bits = 6'h00;
  logic        req_four_lane = 1'b0;
  logic        req_read = 1'b0;
  logic        hold_req = 1'b0;
  logic        wp_level = 1'b1;
  logic        quad_enable = 1'b0;
  logic        protect_complement = 1'b0;
  logic [4:0]  protect_bits = 5'h00;
  logic [1:0]  status_lock = 2'h0;
  logic        busy = 1'b0;
  logic        req_ready_q, rd_valid_q, four_q, latch_q, pdown_q, hold_q, go_q, ref_q;
  logic [7:0]  rd_data_q, rd_byte, code_q;
  logic [23:0] addr_q;
  int          miscompares = 0;
  int          num_checks = 0;
  int          n_go = 0;
  int          n_ref = 0;
  int          d_go, d_ref;
  int          cycles = 0;
  // Layout: refused, complement, protect bits, sector address
  logic [30:0] tbl [16] = '{31'h413f0000, 31'h013ef000, 31'h46200000, 31'h061ff000, 31'h4900f000,
    31'h09010000, 31'h513ff000, 31'h113fe000, 31'h5c007000, 31'h1c008000, 31'h47000000, 31'h60100000,
    31'h213f0000, 31'h613ef000, 31'h313ff000, 31'h713fe000};

  always #5 core_clk = ~core_clk;
  sfl_link_if lnk ();
  sfl_host u_sfl_host (.core_clk, .rst, .req_valid, .req_opcode, .req_payload, .req_payload_bits, .req_four_lane,
    .req_read, .req_ready_q, .rd_valid_q, .rd_data_q, .hold_req, .wp_level, .link(lnk.host));
  sfl_device u_sfl_device (.link(lnk.device), .core_clk, .rst, .quad_enable, .protect_complement, .protect_bits,
    .status_lock, .busy, .four_lane_command_mode_q(four_q), .write_enable_latch_q(latch_q),
    .deep_power_down_q(pdown_q), .hold_active_q(hold_q), .op_go_q(go_q), .op_refused_q(ref_q),
    .op_code_q(code_q), .op_addr_q(addr_q));
  sfl_link_props u_sfl_link_props (.core_clk, .rst, .sclk(lnk.sclk), .cs_n(lnk.cs_n), .host_do(lnk.host_do),
    .host_oe(lnk.host_oe), .dev_do(lnk.dev_do), .dev_oe(lnk.dev_oe), .lane(lnk.lane));

  // ----------------------------------------
  // Pulse counting and hang limit
  // ----------------------------------------
  always @(negedge core_clk) begin
    if (go_q === 1'b1) n_go++;
    if (ref_q === 1'b1) n_ref++;
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      final_report();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic pulses(input int g, input int r);
    check(d_go, g);
    check(d_ref, r);
  endtask

  task automatic send(input logic [7:0] op, input logic [23:0] pl = 24'h000000, input logic [5:0] nb = 6'h00,
                      input logic rd = 1'b0);
    int g0;
    int r0;
    g0 = n_go;
    r0 = n_ref;
    @(posedge core_clk);
    req_opcode <= op;
    req_payload <= pl;
    req_payload_bits <= nb;
    req_read <= rd;
    req_valid <= 1'b1;
    @(posedge core_clk);
    req_valid <= 1'b0;
    do begin
      @(negedge core_clk);
      if (rd_valid_q === 1'b1) rd_byte = rd_data_q;
    end while (req_ready_q !== 1'b1);
    repeat (10) @(negedge core_clk);
    d_go = n_go - g0;
    d_ref = n_ref - r0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_latch;
    check(latch_q, 1'b0);
    check(four_q, 1'b0);
    send(`SFL_OP_SE, 24'h123000, `SFL_ADDR_BITS);
    pulses(0, 1);
    send(`SFL_OP_SET_WEL);
    check(latch_q, 1'b1);
    send(`SFL_OP_RDSR, 24'h000000, 6'h00, 1'b1);
    check(rd_byte, 8'h02);
    send(`SFL_OP_SE, 24'h123000, `SFL_ADDR_BITS);
    pulses(1, 0);
    check(addr_q, 24'h123000);
    check(latch_q, 1'b0);
    send(`SFL_OP_SET_WEL);
    send(`SFL_OP_CLR_WEL);
    check(latch_q, 1'b0);
    $display("latch test done");
  endtask

  task automatic t_protect;
    foreach (tbl[i]) begin
      @(posedge core_clk);
      protect_complement <= tbl[i][29];
      protect_bits <= tbl[i][28:24];
      send(`SFL_OP_SET_WEL);
      send(`SFL_OP_SE, tbl[i][23:0], `SFL_ADDR_BITS);
      pulses(!tbl[i][30], tbl[i][30]);
      check(latch_q, tbl[i][30]);
    end
    $display("protect test done");
  endtask

  task automatic t_lock;
    @(posedge core_clk);
    protect_complement <= 1'b0;
    protect_bits <= 5'h00;
    status_lock <= 2'h1;
    wp_level <= 1'b0;
    send(`SFL_OP_SET_WEL);
    send(`SFL_OP_STATUS_WRITE_CMD, 24'h3c0000, `SFL_DATA_BITS);
    pulses(0, 1);
    @(posedge core_clk);
    wp_level <= 1'b1;
    send(`SFL_OP_SET_WEL);
    send(`SFL_OP_STATUS_WRITE_CMD, 24'h3c0000, `SFL_DATA_BITS);
    pulses(1, 0);
    check(addr_q[7:0], 8'h3c);
    @(posedge core_clk);
    status_lock <= 2'h2;
    send(`SFL_OP_SET_WEL);
    send(`SFL_OP_STATUS_WRITE_CMD, 24'h000000, `SFL_DATA_BITS);
    pulses(0, 1);
    @(posedge core_clk);
    status_lock <= 2'h0;
    $display("lock test done");
  endtask

  task automatic t_quad;
    send(`SFL_OP_QPI_ON);
    pulses(0, 1);
    check(four_q, 1'b0);
    send(`SFL_OP_SET_WEL);
    send(`SFL_OP_QPP, 24'h100000, `SFL_ADDR_BITS);
    pulses(0, 1);
    send(`SFL_OP_QOR);
    pulses(0, 1);
    @(posedge core_clk);
    quad_enable <= 1'b1;
    send(`SFL_OP_QPP, 24'h100000, `SFL_ADDR_BITS);
    pulses(1, 0);
    send(`SFL_OP_QPI_ON);
    check(four_q, 1'b1);
    @(posedge core_clk);
    req_four_lane <= 1'b1;
    send(`SFL_OP_QPI_OFF);
    check(four_q, 1'b0);
    @(posedge core_clk);
    req_four_lane <= 1'b0;
    send(`SFL_OP_QPI_ON);
    @(posedge core_clk);
    req_four_lane <= 1'b1;
    send(`SFL_OP_RST_EN);
    send(`SFL_OP_RST);
    check(four_q, 1'b0);
    @(posedge core_clk);
    req_four_lane <= 1'b0;
    quad_enable <= 1'b0;
    $display("quad test done");
  endtask

  task automatic t_pdown;
    send(`SFL_OP_CLR_WEL);
    send(`SFL_OP_DP);
    check(pdown_q, 1'b1);
    send(`SFL_OP_SET_WEL);
    check(latch_q, 1'b0);
    send(`SFL_OP_RDP);
    check(pdown_q, 1'b0);
    $display("power-down test done");
  endtask

  task automatic t_hold;
    send(`SFL_OP_SET_WEL);
    fork
      send(`SFL_OP_RDSR, 24'h000000, 6'h00, 1'b1);
      begin
        repeat (70) @(posedge core_clk);
        hold_req <= 1'b1;
        repeat (40) @(negedge core_clk);
        check(hold_q, 1'b1);
        check(lnk.dev_oe[1], 1'b0);
        @(posedge core_clk);
        hold_req <= 1'b0;
      end
    join
    check(rd_byte, 8'h02);
    check(hold_q, 1'b0);
    check(latch_q, 1'b1);
    $display("hold test done");
  endtask

  // ----------------------------------------
  // Main sequence and verdict
  // ----------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    rd_byte = 8'h00;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_latch();
    t_protect();
    t_lock();
    t_quad();
    t_pdown();
    t_hold();
    final_report();
  end
endmodule

// File: testbench/sfl_link_props.sv
/*
  Link pin checks between the flash host end and the flash device end.
  Assumes core_clk samples the link pins and rst is active high.
*/
module sfl_link_props (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Link pins
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic [3:0] host_do,
  input wire logic [3:0] host_oe,
  input wire logic [3:0] dev_do,
  input wire logic [3:0] dev_oe,
  input wire logic [3:0] lane
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Clock framing
  // ----------------------------------------
  property p_clk_in_frame; sclk |-> !cs_n; endproperty
  a_clk_in_frame: assert property (p_clk_in_frame) else $error("link clock high outside frame");
  property p_frame_start; $fell(cs_n) |-> !sclk [*3] ##1 sclk; endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame does not open low then rise");
  property p_high_phase; $rose(sclk) |-> sclk [*3] ##1 !sclk; endproperty
  a_high_phase: assert property (p_high_phase) else $error("link clock high phase wrong");

  // ----------------------------------------
  // Lane timing and ownership
  // ----------------------------------------
  property p_dev_on_fall; dev_oe[1] && $past(dev_oe[1]) && $changed(dev_do[1]) |-> $fell(sclk); endproperty
  a_dev_on_fall: assert property (p_dev_on_fall) else $error("device output moved off falling edge");
  property p_host_on_fall; !cs_n && $past(!cs_n) && host_oe[0] && $past(host_oe[0]) && $changed(host_do[0])
    |-> $fell(sclk); endproperty
  a_host_on_fall: assert property (p_host_on_fall) else $error("host data moved off falling edge");
  property p_no_fight; (host_oe & dev_oe) == 4'h0; endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive one lane");
  property p_dev_quiet; cs_n |-> dev_oe == 4'h0; endproperty
  a_dev_quiet: assert property (p_dev_quiet) else $error("device drives while deselected");
  property p_pins_idle; cs_n |-> host_oe[3:2] == 2'h3; endproperty
  a_pins_idle: assert property (p_pins_idle) else $error("protect and hold pins left floating");
endmodule
